/* verilog/rupb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rupb_params.svh"
module rupb_top (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Access classification
    input wire logic [15:0] RAM_OFFSET,
    output rupb_pkg::rupb_region_t RAM_REGION,
    output logic RAM_IN_RANGE
);
    import rupb_pkg::*;
    // ***************************************
    // Register state
    // ***************************************
    logic [5:0] udb_reg, udb_next; // User data base field
    logic [5:0] upb_reg, upb_next; // User program base field
    logic [5:0] kpb_reg, kpb_next; // Kernel program base field
    logic [6:0] rsz_reg, rsz_next; // RAM size in KB
    logic [31:0] rdata_reg, rdata_next; // Read data
    rupb_state_t state_reg, state_next; // Bus answer state
    rupb_cmp_if cmp (); // Bases bundled for the classifier
    // ***************************************
    // Field helpers
    // ***************************************
    // Place a base field in a 32-bit word, upper and lower bits zero
    function automatic logic [31:0] base_word(input logic [5:0] f);
        base_word = {16'h0000, f, 10'h000};
    endfunction : base_word
    // Field write honours byte lane 1 only
    function automatic logic [5:0] base_wr(input logic [5:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
        base_wr = be[1] ? d[`RUPB_BASE_HI:`RUPB_BASE_LO] : old;
    endfunction : base_wr
    // ***************************************
    // Bus decode
    // ***************************************
    // One wait cycle per access: answer in the ACK cycle
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) && state_reg != RUPB_ACK;
    // Next-state and write decode
    always_comb begin
        udb_next = udb_reg;
        upb_next = upb_reg;
        kpb_next = kpb_reg;
        rsz_next = rsz_reg;
        rdata_next = rdata_reg;
        state_next = RUPB_IDLE;
        case (state_reg)
            RUPB_IDLE: begin
                if (AVS_READ) begin
                    // Read: capture the word now so it stands through ACK
                    state_next = RUPB_ACK;
                    case (AVS_ADDRESS)
                        `RUPB_OFF_UDB: rdata_next = base_word(udb_reg);
                        `RUPB_OFF_UPB: rdata_next = base_word(upb_reg);
                        `RUPB_OFF_KPB: rdata_next = base_word(kpb_reg);
                        `RUPB_OFF_RSZ: rdata_next = {16'h0000, rsz_reg[5:0], 10'h000};
                        default: rdata_next = 32'h00000000; // Unmapped reads zero
                    endcase
                end else if (AVS_WRITE) begin
                    // Write: the field lands on this edge, the answer follows
                    state_next = RUPB_ACK;
                    case (AVS_ADDRESS)
                        `RUPB_OFF_UDB: udb_next = base_wr(udb_reg, AVS_WRITEDATA,
                                                          AVS_BYTEENABLE);
                        `RUPB_OFF_UPB: upb_next = base_wr(upb_reg, AVS_WRITEDATA,
                                                          AVS_BYTEENABLE);
                        `RUPB_OFF_KPB: kpb_next = base_wr(kpb_reg, AVS_WRITEDATA,
                                                          AVS_BYTEENABLE);
                        `RUPB_OFF_RSZ: rsz_next = {1'b0, base_wr(rsz_reg[5:0],
                                                   AVS_WRITEDATA, AVS_BYTEENABLE)};
                        default: ; // Unmapped writes dropped
                    endcase
                end
            end
            // One answer cycle, then ready for the next request
            RUPB_ACK: state_next = RUPB_IDLE;
            default: state_next = RUPB_IDLE;
        endcase
    end
    // ***************************************
    // Register update
    // ***************************************
    // Registers; reset gives all RAM to kernel data
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            udb_reg <= `RUPB_RESET_BASE;
            upb_reg <= `RUPB_RESET_BASE;
            kpb_reg <= `RUPB_RESET_BASE;
            rsz_reg <= `RUPB_RESET_RSZ; // 32 KB until software says otherwise
            rdata_reg <= 32'h00000000;
            state_reg <= RUPB_IDLE;
        end else begin
            udb_reg <= udb_next;
            upb_reg <= upb_next;
            kpb_reg <= kpb_next;
            rsz_reg <= rsz_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
        end
    end
    // Read data straight from its flop, never from the decode
    assign AVS_READDATA = rdata_reg;
    // ***************************************
    // Classifier
    // ***************************************
    // Carry bases to the classifier; ordering is software's duty, a bad
    // order is not flagged, user program wins, then user data, then kernel program
    assign cmp.kpb = kpb_reg;
    assign cmp.udb = udb_reg;
    assign cmp.upb = upb_reg;
    assign cmp.rsz = rsz_reg;
    rupb_classify u_cls (
        .cfg(cmp),
        .offs(RAM_OFFSET),
        .region(RAM_REGION),
        .in_range(RAM_IN_RANGE)
    );
    // ***************************************
    // Checks
    // ***************************************
    // Field write to the user data base, answered this cycle
    sequence s_udb_wr;
        AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `RUPB_OFF_UDB && AVS_BYTEENABLE[1];
    endsequence
    a_udb_write: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        s_udb_wr |=> udb_reg == $past(AVS_WRITEDATA[15:10])) else $error("udb write lost");
    a_upb_write: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `RUPB_OFF_UPB && AVS_BYTEENABLE[1]
        |=> upb_reg == $past(AVS_WRITEDATA[15:10])) else $error("upb write lost");
    // Low ten bits of every answer are zero
    a_low_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[9:0] == 10'h000)
        else $error("low bits not zero");
    a_high_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
        else $error("high bits not zero");
    // Reset leaves both user bases cleared
    a_reset_kdata: assert property (@(posedge SYS_CLK)
        $rose(RST_B) |-> udb_reg == 6'h00 && upb_reg == 6'h00) else $error("bases not reset");
    a_udb_read: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `RUPB_OFF_UDB
        |-> AVS_READDATA[15:10] == udb_reg) else $error("udb readback wrong");
    // Exactly one wait state per access
    a_wait_one: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        $rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("answer timing wrong");
    // Offset at or above the user program base
    a_class_up: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        upb_reg != 6'h00 && RAM_OFFSET[15:10] >= upb_reg |-> RAM_REGION == RUPB_UPROG)
        else $error("user program class wrong");
    a_class_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        udb_reg == 6'h00 && upb_reg == 6'h00 && kpb_reg == 6'h00
        |-> RAM_REGION == RUPB_KDATA) else $error("reset class wrong");
    // Any read answered this cycle
    sequence s_rd_done;
        AVS_READ && !AVS_WAITREQUEST;
    endsequence
    // User program base reads back its field
    a_upb_read: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `RUPB_OFF_UPB
        |-> AVS_READDATA[15:10] == upb_reg) else $error("upb readback wrong");
    // Read data stands in the cycle after the answer
    a_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        s_rd_done |=> $stable(AVS_READDATA)) else $error("read data moved");
    // Unmapped places read as zero
    a_unmapped_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS != `RUPB_OFF_UDB
        && AVS_ADDRESS != `RUPB_OFF_UPB && AVS_ADDRESS != `RUPB_OFF_KPB
        && AVS_ADDRESS != `RUPB_OFF_RSZ |-> AVS_READDATA == 32'h00000000)
        else $error("unmapped read not zero");
    // Write without byte lane 1 leaves the user data base alone
    a_udb_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == `RUPB_OFF_UDB && !AVS_BYTEENABLE[1]
        |=> $stable(udb_reg)) else $error("udb changed without lane");
    // Write without byte lane 1 leaves the user program base alone
    a_upb_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == `RUPB_OFF_UPB && !AVS_BYTEENABLE[1]
        |=> $stable(upb_reg)) else $error("upb changed without lane");
    // Between user data and user program bases
    a_class_ud: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        udb_reg != 6'h00 && RAM_OFFSET[15:10] >= udb_reg
        && (upb_reg == 6'h00 || RAM_OFFSET[15:10] < upb_reg)
        |-> RAM_REGION == RUPB_UDATA) else $error("user data class wrong");
    // Between kernel program and user data bases
    a_class_kp: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        kpb_reg != 6'h00 && RAM_OFFSET[15:10] >= kpb_reg
        && (udb_reg == 6'h00 || RAM_OFFSET[15:10] < udb_reg)
        && (upb_reg == 6'h00 || RAM_OFFSET[15:10] < upb_reg)
        |-> RAM_REGION == RUPB_KPROG) else $error("kernel program class wrong");
    // Below every programmed base
    a_class_kd: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (kpb_reg == 6'h00 || RAM_OFFSET[15:10] < kpb_reg)
        && (udb_reg == 6'h00 || RAM_OFFSET[15:10] < udb_reg)
        && (upb_reg == 6'h00 || RAM_OFFSET[15:10] < upb_reg)
        |-> RAM_REGION == RUPB_KDATA) else $error("kernel data class wrong");
    // Offsets past the RAM size are flagged
    a_range_end: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        {1'b0, RAM_OFFSET[15:10]} >= rsz_reg |-> !RAM_IN_RANGE)
        else $error("range flag wrong");
    // Class is always a single region
    a_region_hot: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        $onehot(RAM_REGION)) else $error("region not one-hot");
endmodule : rupb_top
`default_nettype wire

/* common/rupb_params.svh */
`ifndef RUPB_PARAMS_SVH
`define RUPB_PARAMS_SVH
// ***************************************
// Register map and field layout
// ***************************************
`define RUPB_OFF_UDB 4'h0
`define RUPB_OFF_UPB 4'h4
`define RUPB_OFF_KPB 4'h8
`define RUPB_OFF_RSZ 4'hc
`define RUPB_BASE_HI 15
`define RUPB_BASE_LO 10
`define RUPB_BASE_W 6
`define RUPB_RESET_BASE 6'h00
`define RUPB_RESET_RSZ 7'h20
`define RUPB_FIELD_LSB 10
`endif

/* common/rupb_pkg.sv */
// ***************************************
// Types shared by the partition block
// ***************************************
package rupb_pkg;
    // Region classes of a RAM offset
    typedef enum logic [3:0] {
        RUPB_KDATA = 4'h1,
        RUPB_KPROG = 4'h2,
        RUPB_UDATA = 4'h4,
        RUPB_UPROG = 4'h8
    } rupb_region_t;
    // Bus answer states, one-hot
    typedef enum logic [1:0] {
        RUPB_IDLE = 2'h1,
        RUPB_ACK = 2'h2
    } rupb_state_t;
endpackage : rupb_pkg

/* common/rupb_cmp_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ***************************************
// Bases carried to the classifier
// ***************************************
interface rupb_cmp_if;
    logic [5:0] kpb; // Kernel program base, KB units
    logic [5:0] udb; // User data base
    logic [5:0] upb; // User program base
    logic [6:0] rsz; // RAM size, KB units
    modport regs (output kpb, udb, upb, rsz);
    modport cls (input kpb, udb, upb, rsz);
endinterface : rupb_cmp_if
`default_nettype wire

/* verilog/rupb_classify.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rupb_params.svh"
// ***************************************
// Region classifier
// ***************************************
module rupb_classify (
    // Bases
    rupb_cmp_if.cls cfg,
    // Offset in and class out
    input wire logic [15:0] offs,
    output rupb_pkg::rupb_region_t region,
    output logic in_range
);
    import rupb_pkg::*;
    logic [5:0] kb; // Offset in KB units
    assign kb = offs[`RUPB_BASE_HI:`RUPB_BASE_LO];
    // Zero base means the region is absent; ordered compare
    always_comb begin
        region = RUPB_KDATA;
        if (cfg.upb != `RUPB_RESET_BASE && kb >= cfg.upb) begin
            region = RUPB_UPROG;
        end else if (cfg.udb != `RUPB_RESET_BASE && kb >= cfg.udb) begin
            region = RUPB_UDATA;
        end else if (cfg.kpb != `RUPB_RESET_BASE && kb >= cfg.kpb) begin
            region = RUPB_KPROG;
        end
    end
    // Every region, kernel or user, stops at the RAM size
    assign in_range = {1'b0, kb} < cfg.rsz;
endmodule : rupb_classify
`default_nettype wire

/* test/rupb_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rupb_params.svh"
module rupb_top_tb;
    import rupb_pkg::*;
    // ***************************************
    // Stimulus, observation and counters
    // ***************************************
    logic sys_clk, rst_b, rd, wr; // Clock, reset, strobes
    logic [3:0] addr, be; // Address, byte enables
    logic [31:0] wdata, rdata, q; // Bus data and last answer
    logic [15:0] offs; // Offset under classification
    logic [15:0] ram_top; // First offset past the programmed RAM size
    logic wait_req, in_rng; // Bus stall and range flag
    rupb_region_t region; // Class of the offset
    int error_cnt = 0;
    int check_count = 0;
    rupb_top DUT (.SYS_CLK(sys_clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .RAM_OFFSET(offs), .RAM_REGION(region),
        .RAM_IN_RANGE(in_rng));
    // Free running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Compare and log one value
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One bus access; request held until the stall is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) error_cnt++;
        q = rdata; // Read data taken at the answering edge
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // Classify one offset; judge range, and class only when inside the RAM
    task automatic classify(input logic [15:0] o, input rupb_region_t exp);
        @(posedge sys_clk);
        offs <= o;
        @(negedge sys_clk);
        check("in_range", {31'h0, in_rng}, {31'h0, o < ram_top});
        if (o < ram_top) check("region", {28'h0, region}, {28'h0, exp});
    endtask : classify
    // ***************************************
    // Scenarios
    // ***************************************
    // Both bases cleared, whole RAM kernel data
    task automatic t_reset_state;
        bus(1'b0, `RUPB_OFF_UDB, 32'h0, 4'hf);
        check("udb_reset", q, 32'h0);
        bus(1'b0, `RUPB_OFF_UPB, 32'h0, 4'hf);
        check("upb_reset", q, 32'h0);
        bus(1'b0, `RUPB_OFF_RSZ, 32'h0, 4'hf);
        check("size_reset", q, 32'h00008000);
        classify(16'h0000, RUPB_KDATA);
        classify(16'h7ffc, RUPB_KDATA);
    endtask : t_reset_state
    // All ones written: only the 1 KB field sticks; unmapped place ignored
    task automatic t_field_mask;
        bus(1'b1, `RUPB_OFF_UDB, 32'hffffffff, 4'hf);
        bus(1'b0, `RUPB_OFF_UDB, 32'h0, 4'hf);
        check("udb_mask", q, 32'h0000fc00);
        bus(1'b1, `RUPB_OFF_UDB, 32'h00000000, 4'hd);
        bus(1'b0, `RUPB_OFF_UDB, 32'h0, 4'hf);
        check("udb_no_be", q, 32'h0000fc00);
        bus(1'b1, `RUPB_OFF_UPB, 32'hffffffff, 4'hf);
        bus(1'b0, `RUPB_OFF_UPB, 32'h0, 4'hf);
        check("upb_mask", q, 32'h0000fc00);
        bus(1'b1, `RUPB_OFF_UPB, 32'h00000400, 4'hd);
        bus(1'b0, `RUPB_OFF_UPB, 32'h0, 4'hf);
        check("upb_no_be", q, 32'h0000fc00);
        bus(1'b1, 4'h2, 32'hffffffff, 4'hf);
        bus(1'b0, 4'h2, 32'h0, 4'hf);
        check("unmapped", q, 32'h0);
    endtask : t_field_mask
    // Ordered partition 2 KB / 8 KB / 16 KB, boundaries on both sides
    task automatic t_partition;
        bus(1'b1, `RUPB_OFF_KPB, 32'h00000800, 4'hf);
        bus(1'b1, `RUPB_OFF_UDB, 32'h00002000, 4'hf);
        bus(1'b1, `RUPB_OFF_UPB, 32'h00004000, 4'hf);
        bus(1'b0, `RUPB_OFF_UDB, 32'h0, 4'hf);
        check("udb_val", q, 32'h00002000);
        bus(1'b0, `RUPB_OFF_UPB, 32'h0, 4'hf);
        check("upb_val", q, 32'h00004000);
        bus(1'b0, `RUPB_OFF_KPB, 32'h0, 4'hf);
        check("kpb_val", q, 32'h00000800);
        classify(16'h07fc, RUPB_KDATA);
        classify(16'h0800, RUPB_KPROG);
        classify(16'h1ffc, RUPB_KPROG);
        classify(16'h2000, RUPB_UDATA);
        classify(16'h3ffc, RUPB_UDATA);
        classify(16'h4000, RUPB_UPROG);
        classify(16'h7ffc, RUPB_UPROG);
        classify(16'h8000, RUPB_UPROG);
        // Shrink the RAM to 24 KB, still above every base
        bus(1'b1, `RUPB_OFF_RSZ, 32'h00006000, 4'hf);
        ram_top = 16'h6000;
        bus(1'b0, `RUPB_OFF_RSZ, 32'h0, 4'hf);
        check("size_val", q, 32'h00006000);
        classify(16'h5ffc, RUPB_UPROG);
        classify(16'h6000, RUPB_UPROG);
    endtask : t_partition
    // Reset in mid-run wipes the partition
    task automatic t_rereset;
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        ram_top = 16'h8000; // Size register back at its reset value
        t_reset_state();
    endtask : t_rereset
    // Single place where the run ends
    task automatic give_verdict;
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    // Main sequence
    initial begin
        {rst_b, rd, wr, addr, be, wdata, offs} = '0;
        ram_top = 16'h8000; // Reset size: 32 KB
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset_state();
        t_field_mask();
        t_partition();
        t_rereset();
        give_verdict();
    end
    // Watchdog, far beyond the hundred or so cycles needed
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
endmodule : rupb_top_tb
`default_nettype wire
